//--- src/mae_defs.svh
// Register offsets, field positions, reset values and timing figures of the averaging engine.
`ifndef MAE_DEFS_SVH
`define MAE_DEFS_SVH
`define MAE_ADDR_CTRL 8'h00
`define MAE_ADDR_COEF 8'h04
`define MAE_ADDR_STATUS 8'h08
`define MAE_CTRL_ENABLE_BIT 0
`define MAE_CTRL_TYPE_BIT 1
`define MAE_CTRL_AUTO_BIT 2
`define MAE_CTRL_SLOW_BIT 3
`define MAE_COEF_K_LSB 0
`define MAE_COEF_M_LSB 16
`define MAE_STAT_ACTIVE_BIT 0
`define MAE_STAT_REJECT_BIT 1
`define MAE_STAT_EXTRA_BIT 2
`define MAE_K_MIN 7'h02
`define MAE_K_MAX 7'h40
`define MAE_M_MIN 7'h08
`define MAE_M_MAX 7'h40
`define MAE_K_RESET 7'h02
`define MAE_M_RESET 7'h08
`define MAE_CLK_HZ 10000000
`define MAE_INTERVAL_FAST_MS 10
`define MAE_INTERVAL_SLOW_MS 50
`endif

//--- src/mae_pkg.sv
// Types shared by the averaging engine modules.
package mae_pkg;
  typedef enum logic {AVG_EXP, AVG_MOVING} mae_avg_kind_type;
  typedef enum logic [2:0] {
    CLS_DIRECT_NORMAL,
    CLS_DIRECT_HARMONIC,
    CLS_DERIVED_NORMAL,
    CLS_DERIVED_HARMONIC,
    CLS_NEVER
  } mae_class_type;
endpackage

//--- src/mae_reg_if.sv
// Register access path between the bus slave and the engine registers.
`timescale 1ns/1ns
interface mae_reg_if;
  logic [7:0] addr;
  logic wr_en;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  modport bus (output addr, output wr_en, output wr_data, input rd_data);
  modport regs (input addr, input wr_en, input wr_data, output rd_data);
endinterface

//--- src/mae_ahb_slave.sv
// AHB-Lite slave that turns single word transfers into register accesses.
`timescale 1ns/1ns
module mae_ahb_slave (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite slave signals.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Register side.
  mae_reg_if.bus regs
);
  logic pend_wr;
  logic pend_rd;
  logic [7:0] pend_addr;
  logic take;

  // A transfer is taken only when selected, active, word sized and the bus is ready.
  assign take = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign regs.addr = pend_addr;
  assign regs.wr_en = pend_wr;
  assign regs.wr_data = hwdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Address phase capture; a stalled data phase drops the pending flags.
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_wr <= 1'h0;
      pend_rd <= 1'h0;
      pend_addr <= 8'h00;
    end else if (hready) begin
      pend_wr <= take && hwrite;
      pend_rd <= take && !hwrite;
      pend_addr <= haddr[7:0];
    end else begin
      pend_wr <= 1'h0;
      pend_rd <= 1'h0;
    end
  end

  // Reads insert one wait state so that read data comes from a flip-flop.
  always_ff @(posedge clk) begin
    if (reset) begin
      hreadyout <= 1'h1;
    end else begin
      hreadyout <= !(take && !hwrite);
    end
  end

  // Read data is loaded during the wait state.
  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (pend_rd && !hreadyout) begin
      hrdata <= regs.rd_data;
    end
  end

  // The slave always answers OKAY.
  always_ff @(posedge clk) begin
    hresp <= 1'h0;
  end

  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_one_wait: assert property (@(posedge clk) disable iff (reset)
    take && !hwrite |=> s_read_wait)
    else $error("read answer not after one wait state");
endmodule // mae_ahb_slave

//--- src/mae_window_mem.sv
// Per-channel history of measurements for the sliding-window average.
`timescale 1ns/1ns
module mae_window_mem #(
  parameter int CHANNELS = 8,
  parameter int DEPTH = 64,
  parameter int VALUE_W = 24
) (
  // Clock.
  input wire logic clk,
  // Write and read port, one channel and slot at a time.
  input wire logic wr_en,
  input wire logic [$clog2(CHANNELS)-1:0] ch,
  input wire logic [$clog2(DEPTH)-1:0] idx,
  input wire logic [VALUE_W-1:0] wdata,
  output logic [VALUE_W-1:0] rdata
);
  logic [VALUE_W-1:0] mem [CHANNELS][DEPTH];

  // The slot about to be overwritten is read in the same cycle.
  assign rdata = mem[ch][idx];

  // Storage is flip-flops; only valid slots are ever read back.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[ch][idx] <= wdata;
    end
  end
endmodule // mae_window_mem

//--- src/mae_engine.sv
// Measurement averaging engine: registers, interval timer and averaging datapath.
`timescale 1ns/1ns
`include "mae_defs.svh"

// Behaviour
// - Decay mode: add difference divided by constant.
// - First decay output equals first measurement.
// - Decay constant limited to 2 through 64.
// - Window mode: mean of latest m samples.
// - Window count limited to 8 through 64.
// - Auto update mode allows decay mode only.
// - Enable control; active indicator follows it.
// - Decay mode also averages harmonic and fundamental.
// - Window mode leaves harmonic quantities raw.
// - Listed normal quantities are averaged directly.
// - Ratios and efficiencies use averaged sources.
// - Synchronous speed, slip use averaged sources.
// - Harmonic derived results use averaged orders.
// - Harmonic factor, phase use averaged powers.
// - Peaks, elapsed time, energies pass unchanged.
// - Harmonic angles, reference frequencies pass unchanged.
// - User functions and events pass unchanged.
// - One averaging step per update interval.
module mae_engine
  import mae_pkg::*;
#(
  parameter int VALUE_W = 24,
  parameter int CHANNELS = 8,
  parameter int WINDOW_MAX = 64,
  parameter int FAST_CYCLES = `MAE_INTERVAL_FAST_MS * (`MAE_CLK_HZ / 1000),
  parameter int SLOW_CYCLES = `MAE_INTERVAL_SLOW_MS * (`MAE_CLK_HZ / 1000),
  localparam int CH_W = $clog2(CHANNELS)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite register slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Measurement results from the computation stage.
  input wire logic update_strobe,
  input wire logic in_valid,
  input wire logic [CH_W-1:0] in_channel,
  input wire mae_class_type in_class,
  input wire logic [VALUE_W-1:0] in_value,
  // Results towards display and output consumers.
  output logic out_valid,
  output logic [CH_W-1:0] out_channel,
  output logic [VALUE_W-1:0] out_value,
  output logic out_averaged,
  output logic out_from_averaged,
  output logic averaging_active_indicator
);
  localparam int SUM_W = VALUE_W + 7;
  localparam int PTR_W = $clog2(WINDOW_MAX);
  localparam int CNT_W = $clog2(SLOW_CYCLES + 1);

  // Elaboration-time check of the parameters the datapath can serve.
  if (VALUE_W < 8 || CHANNELS < 2 || (1 << CH_W) != CHANNELS || WINDOW_MAX != 64 ||
      FAST_CYCLES < 10 || SLOW_CYCLES < FAST_CYCLES) begin : g_check
    $error("mae_engine: unsupported parameter values");
  end

  // Signed quotient used by both averaging paths.
  function automatic logic signed [SUM_W-1:0] avg_div(input logic signed [SUM_W-1:0] num,
                                                       input logic [6:0] den);
    avg_div = num / $signed({1'h0, den});
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus.
  mae_reg_if reg_bus ();
  mae_ahb_slave u_slave (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .regs(reg_bus.bus)
  );

  logic avg_enable, auto_mode, slow_interval, reject_flag, extra_flag, cfg_change, extra_event;
  mae_avg_kind_type avg_type, next_type;
  logic [6:0] k_reg, m_reg, next_k, next_m, wr_k, wr_m;
  logic next_enable, next_auto, next_slow, next_reject;
  logic wr_ctrl, wr_coef, wr_status;
  assign wr_ctrl = reg_bus.wr_en && (reg_bus.addr == `MAE_ADDR_CTRL);
  assign wr_coef = reg_bus.wr_en && (reg_bus.addr == `MAE_ADDR_COEF);
  assign wr_status = reg_bus.wr_en && (reg_bus.addr == `MAE_ADDR_STATUS);
  assign wr_k = reg_bus.wr_data[`MAE_COEF_K_LSB +: 7];
  assign wr_m = reg_bus.wr_data[`MAE_COEF_M_LSB +: 7];

  // Writes that break a range keep the old setting; window mode asked for in auto mode gives decay mode.
  always_comb begin
    next_enable = avg_enable;
    next_type = avg_type;
    next_auto = auto_mode;
    next_slow = slow_interval;
    next_k = k_reg;
    next_m = m_reg;
    next_reject = 1'h0;
    if (wr_ctrl) begin
      next_enable = reg_bus.wr_data[`MAE_CTRL_ENABLE_BIT];
      next_auto = reg_bus.wr_data[`MAE_CTRL_AUTO_BIT];
      next_slow = reg_bus.wr_data[`MAE_CTRL_SLOW_BIT];
      if (reg_bus.wr_data[`MAE_CTRL_TYPE_BIT] && next_auto) begin
        next_type = AVG_EXP;
        next_reject = 1'h1;
      end else begin
        next_type = reg_bus.wr_data[`MAE_CTRL_TYPE_BIT] ? AVG_MOVING : AVG_EXP;
      end
    end
    if (wr_coef) begin
      if (wr_k >= `MAE_K_MIN && wr_k <= `MAE_K_MAX) begin
        next_k = wr_k;
      end else begin
        next_reject = 1'h1;
      end
      if (wr_m >= `MAE_M_MIN && wr_m <= `MAE_M_MAX) begin
        next_m = wr_m;
      end else begin
        next_reject = 1'h1;
      end
    end
  end

  // Configuration registers and the history clear pulse on any relevant change.
  always_ff @(posedge clk) begin
    if (reset) begin
      avg_enable <= 1'h0;
      avg_type <= AVG_EXP;
      auto_mode <= 1'h0;
      slow_interval <= 1'h0;
      k_reg <= `MAE_K_RESET;
      m_reg <= `MAE_M_RESET;
      cfg_change <= 1'h0;
      averaging_active_indicator <= 1'h0;
    end else begin
      avg_enable <= next_enable;
      avg_type <= next_type;
      auto_mode <= next_auto;
      slow_interval <= next_slow;
      k_reg <= next_k;
      m_reg <= next_m;
      cfg_change <= (next_enable && !avg_enable) || (next_type != avg_type) ||
                    (next_m != m_reg);
      averaging_active_indicator <= next_enable;
    end
  end

  // Sticky status flags; a new event wins over a write-one clear.
  always_ff @(posedge clk) begin
    if (reset) begin
      reject_flag <= 1'h0;
      extra_flag <= 1'h0;
    end else begin
      reject_flag <= next_reject ||
                     (reject_flag && !(wr_status && reg_bus.wr_data[`MAE_STAT_REJECT_BIT]));
      extra_flag <= extra_event ||
                    (extra_flag && !(wr_status && reg_bus.wr_data[`MAE_STAT_EXTRA_BIT]));
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    reg_bus.rd_data = 32'h00000000;
    unique case (reg_bus.addr)
      `MAE_ADDR_CTRL: begin
        reg_bus.rd_data[`MAE_CTRL_ENABLE_BIT] = avg_enable;
        reg_bus.rd_data[`MAE_CTRL_TYPE_BIT] = (avg_type == AVG_MOVING);
        reg_bus.rd_data[`MAE_CTRL_AUTO_BIT] = auto_mode;
        reg_bus.rd_data[`MAE_CTRL_SLOW_BIT] = slow_interval;
      end
      `MAE_ADDR_COEF: begin
        reg_bus.rd_data[`MAE_COEF_K_LSB +: 7] = k_reg;
        reg_bus.rd_data[`MAE_COEF_M_LSB +: 7] = m_reg;
      end
      `MAE_ADDR_STATUS: begin
        reg_bus.rd_data[`MAE_STAT_ACTIVE_BIT] = averaging_active_indicator;
        reg_bus.rd_data[`MAE_STAT_REJECT_BIT] = reject_flag;
        reg_bus.rd_data[`MAE_STAT_EXTRA_BIT] = extra_flag;
      end
      default: reg_bus.rd_data = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Update interval: an internal timer in auto mode, otherwise the upstream strobe.
  logic [CNT_W-1:0] interval_cnt, interval_last;
  logic interval_tick;
  assign interval_last = slow_interval ? CNT_W'(SLOW_CYCLES - 1) : CNT_W'(FAST_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (reset) begin
      interval_cnt <= '0;
      interval_tick <= 1'h0;
    end else if (auto_mode) begin
      interval_tick <= (interval_cnt >= interval_last);
      interval_cnt <= (interval_cnt >= interval_last) ? '0 : interval_cnt + CNT_W'(1);
    end else begin
      interval_cnt <= '0;
      interval_tick <= update_strobe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Which quantities are averaged directly and which derive from averaged values.
  logic do_avg, derived_flag, step;
  logic [CHANNELS-1:0] stepped;
  always_comb begin
    do_avg = 1'h0;
    derived_flag = 1'h0;
    unique case (in_class)
      CLS_DIRECT_NORMAL: do_avg = avg_enable;
      CLS_DIRECT_HARMONIC: do_avg = avg_enable && (avg_type == AVG_EXP);
      CLS_DERIVED_NORMAL: derived_flag = avg_enable;
      CLS_DERIVED_HARMONIC: derived_flag = avg_enable && (avg_type == AVG_EXP);
      CLS_NEVER: do_avg = 1'h0;
      default: do_avg = 1'h0;
    endcase
  end

  // A channel takes at most one averaging step per interval.
  assign step = in_valid && do_avg && !stepped[in_channel] && !cfg_change;
  assign extra_event = in_valid && do_avg && stepped[in_channel];

  always_ff @(posedge clk) begin
    if (reset) begin
      stepped <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        stepped[i] <= (stepped[i] && !interval_tick) || (step && in_channel == CH_W'(i));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel averaging state.
  logic [VALUE_W-1:0] exp_state [CHANNELS];
  logic [CHANNELS-1:0] primed;
  logic [SUM_W-1:0] win_sum [CHANNELS];
  logic [6:0] win_fill [CHANNELS];
  logic [PTR_W-1:0] win_ptr [CHANNELS];
  logic signed [VALUE_W-1:0] d_cur, exp_next;
  logic signed [SUM_W-1:0] exp_quot, sum_cur, sum_new;
  logic [6:0] fill_cur, fill_new;
  logic [PTR_W-1:0] ptr_cur, ptr_new;
  logic [VALUE_W-1:0] win_old, mov_next, avg_result;

  assign d_cur = $signed(exp_state[in_channel]);
  assign sum_cur = $signed(win_sum[in_channel]);
  assign fill_cur = win_fill[in_channel];
  assign ptr_cur = win_ptr[in_channel];

  // Decay step: previous output plus the difference over the constant.
  assign exp_quot = avg_div(SUM_W'($signed(in_value)) - SUM_W'(d_cur), k_reg);
  assign exp_next = d_cur + VALUE_W'(exp_quot);

  // Window step: drop the oldest sample once the window is full.
  always_comb begin
    if (fill_cur == m_reg) begin
      sum_new = sum_cur - SUM_W'($signed(win_old)) + SUM_W'($signed(in_value));
      fill_new = fill_cur;
    end else begin
      sum_new = sum_cur + SUM_W'($signed(in_value));
      fill_new = fill_cur + 7'h01;
    end
    ptr_new = ({1'h0, ptr_cur} == m_reg - 7'h01) ? '0 : ptr_cur + PTR_W'(1);
    mov_next = VALUE_W'(avg_div(sum_new, fill_new));
  end
  mae_window_mem #(.CHANNELS(CHANNELS), .DEPTH(WINDOW_MAX), .VALUE_W(VALUE_W)) u_window (
    .clk(clk), .wr_en(step && (avg_type == AVG_MOVING)), .ch(in_channel), .idx(ptr_cur),
    .wdata(in_value), .rdata(win_old)
  );

  // The first decay output takes the measurement itself.
  assign avg_result = (avg_type == AVG_MOVING) ? mov_next :
                      (primed[in_channel] ? VALUE_W'(exp_next) : in_value);

  always_ff @(posedge clk) begin
    if (reset || cfg_change) begin
      primed <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        exp_state[i] <= '0;
        win_sum[i] <= '0;
        win_fill[i] <= 7'h00;
        win_ptr[i] <= '0;
      end
    end else if (step) begin
      if (avg_type == AVG_EXP) begin
        exp_state[in_channel] <= avg_result;
        primed[in_channel] <= 1'h1;
      end else begin
        win_sum[in_channel] <= sum_new;
        win_fill[in_channel] <= fill_new;
        win_ptr[in_channel] <= ptr_new;
      end
    end
  end

  // Output register; everything not stepped passes unchanged.
  always_ff @(posedge clk) begin
    if (reset) begin
      out_valid <= 1'h0;
      out_channel <= '0;
      out_value <= '0;
      out_averaged <= 1'h0;
      out_from_averaged <= 1'h0;
    end else begin
      out_valid <= in_valid;
      out_channel <= in_channel;
      out_value <= step ? avg_result : in_value;
      out_averaged <= step;
      out_from_averaged <= in_valid && derived_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_exp_first;
    in_valid && step && avg_type == AVG_EXP && !primed[in_channel];
  endsequence

  sequence s_harm_window;
    in_valid && avg_enable && avg_type == AVG_MOVING && in_class == CLS_DIRECT_HARMONIC;
  endsequence

  a_exp_first_value: assert property (s_exp_first |=> out_averaged &&
    out_value == $past(in_value))
    else $error("first decay output differs from measurement");
  a_exp_step_value: assert property (step && avg_type == AVG_EXP && primed[in_channel]
    |=> int'($signed(out_value)) == int'($past(d_cur)) +
    (int'($signed($past(in_value))) - int'($past(d_cur))) / int'($past(k_reg)))
    else $error("decay step result wrong");
  a_k_in_range: assert property (k_reg >= `MAE_K_MIN && k_reg <= `MAE_K_MAX)
    else $error("decay constant out of range");
  a_m_in_range: assert property (m_reg >= `MAE_M_MIN && m_reg <= `MAE_M_MAX)
    else $error("window count out of range");
  a_auto_decay_only: assert property (auto_mode |-> avg_type == AVG_EXP)
    else $error("window mode active in auto update mode");
  a_indicator_follow: assert property (wr_ctrl |=>
    averaging_active_indicator == $past(next_enable))
    else $error("active indicator does not follow enable");
  a_harm_window_raw: assert property (s_harm_window |=> !out_averaged &&
    out_value == $past(in_value))
    else $error("harmonic quantity averaged in window mode");
  a_never_pass: assert property (in_valid && in_class == CLS_NEVER
    |=> out_valid && !out_averaged && out_value == $past(in_value))
    else $error("excluded quantity was altered");
  a_fill_bound: assert property (!cfg_change |-> win_fill[0] <= m_reg)
    else $error("window holds more than the count");
  a_hist_clear: assert property (cfg_change |=> win_fill[0] == 7'h00 && !primed[0])
    else $error("history not cleared on change");
  a_tick_spacing: assert property (auto_mode && interval_tick |=> !interval_tick [*8])
    else $error("interval ticks too close");
endmodule // mae_engine

//--- tb/mae_source.sv
// Upstream measurement source model that presents one result per call.
`timescale 1ns/1ns
module mae_source
  import mae_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Measurement stream towards the engine.
  output logic update_strobe,
  output logic in_valid,
  output logic [2:0] in_channel,
  output mae_class_type in_class,
  output logic [23:0] in_value
);
  // The stream starts idle.
  initial begin
    update_strobe = 1'b0;
    in_valid = 1'b0;
    in_channel = 3'h0;
    in_class = CLS_NEVER;
    in_value = 24'h000000;
  end
  // Opens an interval if asked, then holds one result for exactly one cycle.
  task automatic put(input bit tick, input logic [2:0] ch, input mae_class_type cl,
                     input logic [23:0] v);
    // The strobe clears the step marks an edge later, so the result waits one more cycle.
    if (tick) begin
      @(posedge clk);
      update_strobe <= 1'b1;
      @(posedge clk);
      update_strobe <= 1'b0;
    end
    @(posedge clk);
    in_valid <= 1'b1;
    in_channel <= ch;
    in_class <= cl;
    in_value <= v;
    @(posedge clk);
    in_valid <= 1'b0;
    in_channel <= ~ch; // Released lines show the inverse so stale data cannot match.
    in_value <= ~v;
    #1;
  endtask
endmodule // mae_source

//--- tb/tb.sv
// Self-checking bench for the averaging engine.
`timescale 1ns/1ns
module tb;
  import mae_pkg::*;
  logic clk, reset, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic update_strobe, in_valid, out_valid, out_averaged, out_from_averaged;
  logic averaging_active_indicator;
  logic [2:0] in_channel, out_channel;
  logic [23:0] in_value, out_value;
  mae_class_type in_class;
  int failures, checks_done, d, s, n, hist[10];
  logic [6:0] kv[4] = '{7'h01, 7'h41, 7'h40, 7'h02};
  logic [6:0] mv[4] = '{7'h07, 7'h41, 7'h40, 7'h08};
  logic [6:0] ke[4] = '{7'h02, 7'h02, 7'h40, 7'h02};
  logic [6:0] me[4] = '{7'h08, 7'h08, 7'h40, 7'h08};
  int dv[4] = '{100, 0, 0, -37};
  ////////////////////////////////////////////////////////////////////////////////
  // The single slave answers the whole bus.
  assign hready = hreadyout;
  // Engine with short update intervals so auto mode runs quickly.
  mae_engine #(.FAST_CYCLES(20), .SLOW_CYCLES(40)) dut (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .update_strobe(update_strobe),
    .in_valid(in_valid), .in_channel(in_channel), .in_class(in_class),
    .in_value(in_value), .out_valid(out_valid), .out_channel(out_channel),
    .out_value(out_value), .out_averaged(out_averaged),
    .out_from_averaged(out_from_averaged),
    .averaging_active_indicator(averaging_active_indicator)
  );
  // Upstream measurement model.
  mae_source src (.clk(clk), .update_strobe(update_strobe), .in_valid(in_valid),
    .in_channel(in_channel), .in_class(in_class), .in_value(in_value));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // One single AHB-Lite word transfer; waits last until hready is high, limited only by the watchdog.
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
    @(posedge clk);
  endtask
  // Compares a register word or flag.
  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Reads a register and compares it.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h00000000);
    cmp_reg(nm, e, rd);
    cmp_reg("hresp", 32'h00000000, {31'h0, hresp});
  endtask
  // Sends one result and compares the registered output a cycle later.
  task automatic meas(input bit t, input logic [2:0] ch, input mae_class_type c,
                      input int v, input int e, input bit ea, input bit ef);
    src.put(t, ch, c, v[23:0]);
    checks_done++;
    if ({out_valid, out_channel, out_value, out_averaged, out_from_averaged} !==
        {1'b1, ch, e[23:0], ea, ef}) begin
      failures++;
      $display("[ERR] stream expected %h %b%b seen %h %b%b", e[23:0], ea, ef,
               out_value, out_averaged, out_from_averaged);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #(100 * 20000);
    failures++;
    close_out;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence.
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    failures = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd_chk(8'h00, 32'h00000000, "ctrl");
    rd_chk(8'h04, 32'h00080002, "coef");
    rd_chk(8'h08, 32'h00000000, "status");
    rd_chk(8'h0C, 32'h00000000, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h04, {9'h000, 7'h08, 9'h000, kv[i]});
      rd_chk(8'h04, {9'h000, 7'h08, 9'h000, ke[i]}, "coef k");
      rd_chk(8'h08, {30'h0, i < 2, 1'b0}, "reject k");
      bus(1'b1, 8'h08, 32'h00000006);
      bus(1'b1, 8'h04, {9'h000, mv[i], 9'h000, 7'h02});
      rd_chk(8'h04, {9'h000, me[i], 9'h000, 7'h02}, "coef m");
      rd_chk(8'h08, {30'h0, i < 2, 1'b0}, "reject m");
      bus(1'b1, 8'h08, 32'h00000006);
    end
    bus(1'b1, 8'h04, 32'h00080004);
    bus(1'b1, 8'h00, 32'h00000007);
    rd_chk(8'h00, 32'h00000005, "ctrl auto");
    rd_chk(8'h08, 32'h00000003, "status auto");
    bus(1'b1, 8'h08, 32'h00000006);
    $display("test limits done");
    bus(1'b1, 8'h00, 32'h00000000);
    cmp_reg("indicator", 32'h0, {31'h0, averaging_active_indicator});
    meas(1'b1, 3'h6, CLS_DIRECT_NORMAL, 12, 12, 1'b0, 1'b0);
    bus(1'b1, 8'h00, 32'h00000001);
    cmp_reg("indicator", 32'h1, {31'h0, averaging_active_indicator});
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? dv[i] : d + (dv[i] - d) / 4;
      meas(1'b1, 3'h0, CLS_DIRECT_NORMAL, dv[i], d, 1'b1, 1'b0);
      meas(1'b1, 3'h1, CLS_DIRECT_HARMONIC, dv[i], d, 1'b1, 1'b0);
    end
    meas(1'b1, 3'h2, CLS_NEVER, 77, 77, 1'b0, 1'b0);
    meas(1'b1, 3'h3, CLS_DERIVED_NORMAL, 55, 55, 1'b0, 1'b1);
    meas(1'b1, 3'h4, CLS_DERIVED_HARMONIC, 5, 5, 1'b0, 1'b1);
    meas(1'b1, 3'h0, CLS_DIRECT_NORMAL, d, d, 1'b1, 1'b0);
    meas(1'b0, 3'h0, CLS_DIRECT_NORMAL, 500, 500, 1'b0, 1'b0);
    rd_chk(8'h08, 32'h00000005, "status extra");
    $display("test decay done");
    bus(1'b1, 8'h00, 32'h00000003);
    s = 0;
    for (int i = 0; i < 10; i++) begin
      hist[i] = 16 * i + 3 - 40;
      s += hist[i];
      if (i >= 8) s -= hist[i - 8];
      n = (i < 8) ? i + 1 : 8;
      meas(1'b1, 3'h0, CLS_DIRECT_NORMAL, hist[i], s / n, 1'b1, 1'b0);
    end
    meas(1'b1, 3'h1, CLS_DIRECT_HARMONIC, 9, 9, 1'b0, 1'b0);
    meas(1'b1, 3'h4, CLS_DERIVED_HARMONIC, 6, 6, 1'b0, 1'b0);
    meas(1'b1, 3'h3, CLS_DERIVED_NORMAL, 7, 7, 1'b0, 1'b1);
    $display("test window done");
    bus(1'b1, 8'h00, 32'h00000000);
    bus(1'b1, 8'h00, 32'h00000005);
    meas(1'b0, 3'h5, CLS_DIRECT_NORMAL, 64, 64, 1'b1, 1'b0);
    repeat (21) @(posedge clk);
    meas(1'b0, 3'h5, CLS_DIRECT_NORMAL, 0, 48, 1'b1, 1'b0);
    $display("test auto done");
    close_out;
  end
endmodule // tb
